/* File: bench/sar_adc_control_regs_tb_top.sv */
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module sar_adc_control_regs_tb_top;
  // ----------------------------------------
  // Stimulus, observation and instance
  // ----------------------------------------
  typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] r;} reg_row_t;
  typedef struct {logic [7:0] cfg; logic [10:0] ain; int len; logic [9:0] res;} conv_row_t;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic deep_stop_i = 1'b0;
  logic hw_trig_i = 1'b0;
  logic alt_tick_i = 1'b0;
  logic async_tick_i = 1'b0;
  logic alt_run_q = 1'b1;
  logic cmp_above_i;
  logic [7:0] rd_data_o;
  logic [9:0] dac_code_o;
  logic sample_o;
  logic [4:0] channel_o;
  logic [15:0] pin_disable_o;
  logic low_power_o;
  logic irq_o;
  logic [10:0] ain_q = 11'h000;
  logic [7:0] d;
  int n;
  int error_cnt = 0;
  int total_checks = 0;
  reg_row_t reg_rows [7] = '{'{4'h6, 8'h98, 8'h98}, '{4'h1, 8'h7C, 8'h70}, '{4'h4, 8'hFF, 8'h03},
    '{4'h5, 8'h5A, 8'h5A}, '{4'h7, 8'h02, 8'h02}, '{4'h8, 8'h81, 8'h81}, '{4'hF, 8'hFF, 8'h00}};
  conv_row_t conv_rows [10] = '{'{8'h08, 11'h2A5, 4, 10'h2A5}, '{8'h18, 11'h7FF, 24, 10'h3FF},
    '{8'h28, 11'h000, 8, 10'h000}, '{8'h68, 11'h155, 32, 10'h155}, '{8'h09, 11'h100, 8, 10'h100},
    '{8'h0B, 11'h0F0, 0, 10'h0F0}, '{8'h00, 11'h7FF, 4, 10'h0FF}, '{8'h0C, 11'h2A5, 4, 10'h0A9},
    '{8'h04, 11'h1F0, 4, 10'h07C}, '{8'h98, 11'h3FF, 24, 10'h3FF}};
  // Comparator is combinational so each trial code is judged in its own cycle
  assign cmp_above_i = (ain_q >= {1'b0, dac_code_o});
  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    alt_tick_i <= ~alt_tick_i & alt_run_q;
    async_tick_i <= ~async_tick_i;
  end
  sar_adc_control_regs #(.PIN_COUNT(16)) dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o), .deep_stop_i(deep_stop_i), .hw_trig_i(hw_trig_i),
    .alt_tick_i(alt_tick_i), .async_tick_i(async_tick_i), .cmp_above_i(cmp_above_i),
    .dac_code_o(dac_code_o), .sample_o(sample_o), .channel_o(channel_o),
    .pin_disable_o(pin_disable_o), .low_power_o(low_power_o), .irq_o(irq_o));
  // ----------------------------------------
  // Bus and wait tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge mclk_i);
    addr_i <= a;
    wr_data_i <= w;
    wr_en_i <= 1'b1;
    @(posedge mclk_i);
    wr_en_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge mclk_i);
    rd_en_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask : rd
  // Polls a flag bit; a bound that runs out ends the run rather than hanging it
  task automatic poll(input logic [3:0] a, input int b, input logic v);
    int i;
    for (i = 0; i < 600; i++) begin
      rd(a);
      if (d[b] === v) break;
    end
    if (i == 600) begin
      error_cnt++;
      $display("BAD flag_wait exp %h got %h", v, d[b]);
      tally_and_finish();
    end
  endtask : poll
  task automatic samp();
    int i;
    n = 0;
    #1;
    for (i = 0; i < 10 && sample_o !== 1'b1; i++) begin
      @(posedge mclk_i);
      #1;
    end
    while (sample_o === 1'b1 && n < 100) begin
      n++;
      @(posedge mclk_i);
      #1;
    end
    if (i == 10 || n == 100) begin
      error_cnt++;
      $display("BAD sample_wait exp %h got %h", ~sample_o, sample_o);
      tally_and_finish();
    end
  endtask : samp
  task automatic result(input logic [9:0] res);
    rd(4'h2);
    `CHK("result_high", {6'h00, res[9:8]}, d)
    rd(4'h3);
    `CHK("result_low", res[7:0], d)
  endtask : result
  task automatic conv(input conv_row_t c);
    wr(4'h6, c.cfg);
    ain_q <= c.ain;
    wr(4'h0, 8'h43);
    samp();
    if (c.len > 0) `CHK("sample_len", c.len, n)
    rd(4'h1);
    `CHK("active_flag", 1'b1, d[7])
    `CHK("channel", 5'h03, channel_o)
    poll(4'h0, 7, 1'b1);
    `CHK("irq_on", 1'b1, irq_o)
    result(c.res);
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK("irq_off", 1'b0, irq_o)
  endtask : conv
  task automatic cmp_case(input logic [7:0] tc, input logic [10:0] a, input logic ok,
    input logic [9:0] res);
    wr(4'h1, tc);
    ain_q <= a;
    wr(4'h0, 8'h03);
    poll(4'h1, 7, 1'b0);
    rd(4'h0);
    `CHK("cmp_done", ok, d[7])
    result(res);
  endtask : cmp_case
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    #1;
    `CHK("dac_rst", 10'h200, dac_code_o)
    `CHK("pins_rst", 16'h0000, pin_disable_o)
    for (int i = 0; i < 16; i++) begin
      rd(4'(i));
      `CHK("reg_rst", 8'h00, d)
    end
    foreach (reg_rows[i]) begin
      wr(reg_rows[i].a, reg_rows[i].w);
      rd(reg_rows[i].a);
      `CHK("reg_rw", reg_rows[i].r, d)
    end
    `CHK("low_power", 1'b1, low_power_o)
    `CHK("pin_disable", 16'h8102, pin_disable_o)
    wr(4'h1, 8'h00);
    foreach (conv_rows[i]) conv(conv_rows[i]);
    // Reading the high byte must freeze the pair against the next conversion
    wr(4'h6, 8'h08);
    ain_q <= 11'h123;
    wr(4'h0, 8'h03);
    poll(4'h0, 7, 1'b1);
    rd(4'h2);
    ain_q <= 11'h0AB;
    wr(4'h0, 8'h03);
    poll(4'h1, 7, 1'b0);
    rd(4'h3);
    `CHK("locked_low", 8'h23, d)
    wr(4'h4, 8'h02);
    wr(4'h5, 8'h00);
    cmp_case(8'h30, 11'h300, 1'b1, 10'h300);
    cmp_case(8'h30, 11'h100, 1'b0, 10'h300);
    cmp_case(8'h20, 11'h100, 1'b1, 10'h100);
    cmp_case(8'h20, 11'h300, 1'b0, 10'h100);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h23);
    poll(4'h0, 7, 1'b1);
    result(10'h300);
    poll(4'h0, 7, 1'b1);
    wr(4'h0, 8'h03);
    poll(4'h0, 7, 1'b1);
    result(10'h300);
    repeat (60) @(posedge mclk_i);
    rd(4'h0);
    `CHK("single_only", 1'b0, d[7])
    wr(4'h0, 8'h03);
    repeat (2) @(posedge mclk_i);
    wr(4'h0, 8'h05);
    samp();
    `CHK("restart_len", 4, n)
    `CHK("restart_chan", 5'h05, channel_o)
    poll(4'h0, 7, 1'b1);
    result(10'h300);
    wr(4'h1, 8'h40);
    wr(4'h0, 8'h03);
    repeat (20) @(posedge mclk_i);
    rd(4'h1);
    `CHK("hw_no_sw", 1'b0, d[7])
    hw_trig_i <= 1'b1;
    @(posedge mclk_i);
    hw_trig_i <= 1'b0;
    poll(4'h0, 7, 1'b1);
    `CHK("irq_masked", 1'b0, irq_o)
    result(10'h300);
    wr(4'h1, 8'h00);
    // Alternate source stalled: the conversion must wait for its ticks
    alt_run_q <= 1'b0;
    wr(4'h6, 8'h0A);
    wr(4'h0, 8'h03);
    repeat (40) @(posedge mclk_i);
    rd(4'h1);
    `CHK("alt_stall", 1'b1, d[7])
    alt_run_q <= 1'b1;
    poll(4'h0, 7, 1'b1);
    wr(4'h6, 8'h98);
    wr(4'h7, 8'hFF);
    wr(4'h0, 8'h03);
    deep_stop_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    deep_stop_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    `CHK("stop_sample", 1'b0, sample_o)
    `CHK("stop_dac", 10'h200, dac_code_o)
    `CHK("stop_pins", 16'h0000, pin_disable_o)
    `CHK("stop_lowpwr", 1'b0, low_power_o)
    rd(4'h6);
    `CHK("stop_cfg", 8'h00, d)
    rd(4'h0);
    `CHK("stop_chan", 8'h00, d)
    tally_and_finish();
  end
endmodule : sar_adc_control_regs_tb_top
`undef CHK
`default_nettype wire

/* File: hw/adc_ctrl_pkg.sv */
// Constants, register map and state type for the converter control block
//
// Overview of operation
// R1: Deep stop request shuts the converter down at once.
// R2: After deep stop every register holds its reset value; software reconfigures.
// R3: Config bit 7 selects low-power operation, lowering the allowed conversion clock.
// R4: Config bits 6:5 set the clock divide ratio; 00 divides by one.
// R5: Config bit 4 selects the long sample time.
// R6: Config bits 3:2 select resolution; 10 means 10-bit conversions.
// R7: Config bits 1:0 select the divider input clock; 00 is the bus clock.
// R8: Trigger/compare bit 7 reads high while a conversion runs.
// R9: Trigger/compare bit 6 selects software (0) or hardware (1) trigger.
// R10: Trigger/compare bit 5 enables the automatic compare function.
// R11: Trigger/compare bits 3:2 read zero; bits 1:0 reserved, write zero.
// R12: Channel control bit 7 is a read-only completion flag.
// R13: Channel control bit 6 enables the completion interrupt.
// R14: Channel control bit 5 selects continuous conversions, else one per trigger.
// R15: Channel control bits 4:0 select the input channel in binary.
// R16: High byte read first blocks result overwrite until low byte is read.
// R17: The compare value pair holds the threshold for the compare function.
// R18: A set pin control bit disables digital I/O on that analog pin.
// R19: A channel converts whether or not its pin control bit is set.
// R20: Input at or beyond a reference gives full scale or zero code.
// R21: Sample window is 3.5 conversion clocks, or 23.5 with long sample; the code rounds up to 4 and 24.
// R22: Software writes config, then trigger/compare, then channel control last.
// R23: Compare passes at or above threshold (greater set) or below it.
// R24: Software-trigger write to channel control aborts and restarts a conversion.
package adc_ctrl_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_CHAN_CTRL = 4'h0;
  localparam logic [3:0] OFS_TRIG_CMP = 4'h1;
  localparam logic [3:0] OFS_RESULT_HI = 4'h2;
  localparam logic [3:0] OFS_RESULT_LO = 4'h3;
  localparam logic [3:0] OFS_CMP_HI = 4'h4;
  localparam logic [3:0] OFS_CMP_LO = 4'h5;
  localparam logic [3:0] OFS_CONFIG = 4'h6;
  localparam logic [3:0] OFS_PIN_LO = 4'h7;
  localparam logic [3:0] OFS_PIN_HI = 4'h8;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG_LOW_POWER = 7;
  localparam int CFG_DIV_MSB = 6;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LONG_SAMPLE = 4;
  localparam int CFG_MODE_MSB = 3;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_MSB = 1;
  localparam int CFG_CLK_LSB = 0;
  localparam int TC_HW_TRIG = 6;
  localparam int TC_CMP_EN = 5;
  localparam int TC_CMP_GT = 4;
  localparam int CC_IRQ_EN = 6;
  localparam int CC_CONT = 5;
  localparam int CC_CHAN_MSB = 4;
  // ----------------------------------------
  // Encodings and reset values
  // ----------------------------------------
  localparam logic [1:0] MODE_10BIT = 2'h2;
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [7:0] PIN_RST = 8'h00;
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [9:0] SAR_FIRST = 10'h200;
  localparam logic [9:0] LSB_MASK_10 = 10'h001;
  localparam logic [9:0] LSB_MASK_8 = 10'h004;
  // ----------------------------------------
  // Sample window, in half conversion clocks
  // ----------------------------------------
  localparam int SAMPLE_SHORT_HALF = 7;
  localparam int SAMPLE_LONG_HALF = 47;
  localparam logic [4:0] SAMPLE_SHORT_TICKS = 5'((SAMPLE_SHORT_HALF + 1) / 2);
  localparam logic [4:0] SAMPLE_LONG_TICKS = 5'((SAMPLE_LONG_HALF + 1) / 2);
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_t;
endpackage : adc_ctrl_pkg

/* File: hw/conv_clock_div.sv */
// Conversion clock enable generator: source select and power-of-two divider
`timescale 1ns/1ps
`default_nettype none
module conv_clock_div (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clear_i,
  input wire logic [1:0] src_sel_i,
  input wire logic [1:0] div_sel_i,
  input wire logic alt_tick_i,
  input wire logic async_tick_i,
  output logic tick_o
);
  logic half_q;
  logic [2:0] cnt_q;
  logic src_en;
  logic [2:0] limit;

  always_comb begin
    case (src_sel_i) // see R7
      adc_ctrl_pkg::CLK_BUS: src_en = 1'b1;
      adc_ctrl_pkg::CLK_BUS_HALF: src_en = half_q;
      adc_ctrl_pkg::CLK_ALT: src_en = alt_tick_i;
      adc_ctrl_pkg::CLK_ASYNC: src_en = async_tick_i;
      default: src_en = 1'b1;
    endcase
  end

  // Ratio 1, 2, 4 or 8
  assign limit = 3'((4'h1 << div_sel_i) - 4'h1); // see R4

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      half_q <= 1'b0;
    end else if (clear_i) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  // Clearing at start keeps the first sample window a full length
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 3'h0;
    end else if (clear_i) begin
      cnt_q <= 3'h0;
    end else if (src_en) begin
      cnt_q <= (cnt_q == limit) ? 3'h0 : 3'(cnt_q + 3'h1);
    end
  end

  // Combinational so the first tick after a clear is not a bus cycle late
  assign tick_o = src_en && (cnt_q == limit);
endmodule : conv_clock_div
`default_nettype wire

/* File: hw/sar_adc_control_regs.sv */
// Register file, sequencer and successive-approximation logic of the converter
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_regs #(
  parameter int PIN_COUNT = 16
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [7:0] rd_data_o,
  input wire logic deep_stop_i,
  input wire logic hw_trig_i,
  input wire logic alt_tick_i,
  input wire logic async_tick_i,
  input wire logic cmp_above_i,
  output logic [9:0] dac_code_o,
  output logic sample_o,
  output logic [4:0] channel_o,
  output logic [PIN_COUNT-1:0] pin_disable_o,
  output logic low_power_o,
  output logic irq_o
);
  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (PIN_COUNT < 1 || PIN_COUNT > 16) begin : g_bad_pins
    $error("PIN_COUNT must be 1 to 16");
  end

  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  logic [7:0] cfg_q;
  logic hw_trig_q;
  logic cmp_en_q;
  logic cmp_gt_q;
  logic done_q;
  logic irq_en_q;
  logic cont_q;
  logic [4:0] chan_q;
  logic [1:0] cmp_hi_q;
  logic [7:0] cmp_lo_q;
  logic [7:0] pin_lo_q;
  logic [7:0] pin_hi_q;
  logic [9:0] result_q;
  logic lock_q;
  logic sample_q;
  adc_ctrl_pkg::conv_state_t state_q;
  logic [4:0] cnt_q;
  logic [9:0] sar_q;
  logic [9:0] mask_q;
  logic tick;
  logic wr_chan;
  logic rd_hi;
  logic rd_lo;
  logic mode10;
  logic [4:0] sample_ticks;
  logic [9:0] sar_keep;
  logic [9:0] conv_code;
  logic [9:0] cmp_value;
  logic cmp_hit;
  logic start;
  logic finish;
  logic accept;

  assign wr_chan = wr_en_i && addr_i == adc_ctrl_pkg::OFS_CHAN_CTRL;
  assign rd_hi = rd_en_i && addr_i == adc_ctrl_pkg::OFS_RESULT_HI;
  assign rd_lo = rd_en_i && addr_i == adc_ctrl_pkg::OFS_RESULT_LO;
  assign mode10 = cfg_q[adc_ctrl_pkg::CFG_MODE_MSB:adc_ctrl_pkg::CFG_MODE_LSB]
                  == adc_ctrl_pkg::MODE_10BIT; // see R6
  assign sample_ticks = cfg_q[adc_ctrl_pkg::CFG_LONG_SAMPLE] ? adc_ctrl_pkg::SAMPLE_LONG_TICKS
                        : adc_ctrl_pkg::SAMPLE_SHORT_TICKS; // see R5
  assign cmp_value = {cmp_hi_q, cmp_lo_q}; // see R17

  // ----------------------------------------
  // Conversion clock
  // ----------------------------------------
  conv_clock_div u_div (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(start),
    .src_sel_i(cfg_q[adc_ctrl_pkg::CFG_CLK_MSB:adc_ctrl_pkg::CFG_CLK_LSB]),
    .div_sel_i(cfg_q[adc_ctrl_pkg::CFG_DIV_MSB:adc_ctrl_pkg::CFG_DIV_LSB]),
    .alt_tick_i(alt_tick_i),
    .async_tick_i(async_tick_i),
    .tick_o(tick)
  );

  // ----------------------------------------
  // Approximation step and compare
  // ----------------------------------------
  // Comparator high means input at or above trial code; above the top
  // reference every step keeps its bit, so the code saturates at full scale
  assign sar_keep = cmp_above_i ? sar_q : (sar_q & ~mask_q); // see R20
  assign conv_code = mode10 ? sar_keep : {2'h0, sar_keep[9:2]};
  assign finish = state_q == adc_ctrl_pkg::ST_CONVERT && tick
                  && mask_q == (mode10 ? adc_ctrl_pkg::LSB_MASK_10 : adc_ctrl_pkg::LSB_MASK_8);
  assign cmp_hit = !cmp_en_q || (cmp_gt_q ? (conv_code >= cmp_value)
                                          : (conv_code < cmp_value)); // see R10 see R23
  // A blocked pair drops the new result instead of tearing it
  assign accept = finish && cmp_hit && !lock_q && !rd_hi; // see R16
  assign start = !deep_stop_i && ((wr_chan && !hw_trig_q) // see R24
                 || (hw_trig_q && hw_trig_i && state_q == adc_ctrl_pkg::ST_IDLE) // see R9
                 || (finish && cont_q && !wr_chan)); // see R14

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Channel choice ignores pin control, so an unreleased pin still converts
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= adc_ctrl_pkg::ST_IDLE;
      cnt_q <= 5'h00;
      sample_q <= 1'b0;
    end else if (deep_stop_i) begin // see R1
      state_q <= adc_ctrl_pkg::ST_IDLE;
      cnt_q <= 5'h00;
      sample_q <= 1'b0;
    end else if (start) begin // see R19
      state_q <= adc_ctrl_pkg::ST_SAMPLE;
      cnt_q <= 5'h00;
      sample_q <= 1'b1;
    end else if (wr_chan) begin
      state_q <= adc_ctrl_pkg::ST_IDLE;
      sample_q <= 1'b0;
    end else begin
      case (state_q)
        adc_ctrl_pkg::ST_IDLE: begin
          sample_q <= 1'b0;
        end
        adc_ctrl_pkg::ST_SAMPLE: begin
          if (tick) begin
            if (5'(cnt_q + 5'h01) == sample_ticks) begin // see R21
              state_q <= adc_ctrl_pkg::ST_CONVERT;
              sample_q <= 1'b0;
            end
            cnt_q <= 5'(cnt_q + 5'h01);
          end
        end
        adc_ctrl_pkg::ST_CONVERT: begin
          if (finish) begin
            state_q <= adc_ctrl_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= adc_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sar_q <= adc_ctrl_pkg::SAR_FIRST;
      mask_q <= adc_ctrl_pkg::SAR_FIRST;
    end else if (state_q != adc_ctrl_pkg::ST_CONVERT || deep_stop_i) begin
      sar_q <= adc_ctrl_pkg::SAR_FIRST;
      mask_q <= adc_ctrl_pkg::SAR_FIRST;
    end else if (tick) begin
      sar_q <= sar_keep | (mask_q >> 1);
      mask_q <= mask_q >> 1;
    end
  end

  // ----------------------------------------
  // Result, completion flag and read lock
  // ----------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_q <= adc_ctrl_pkg::RESULT_RST;
      done_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (deep_stop_i) begin // see R2
      result_q <= adc_ctrl_pkg::RESULT_RST;
      done_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      if (accept) begin
        result_q <= conv_code;
      end
      // Completion wins over a clear in the same cycle
      if (accept) begin
        done_q <= 1'b1; // see R12
      end else if (wr_chan || rd_lo) begin
        done_q <= 1'b0;
      end
      if (rd_hi) begin
        lock_q <= 1'b1; // see R16
      end else if (rd_lo) begin
        lock_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q <= adc_ctrl_pkg::CONFIG_RST;
      hw_trig_q <= 1'b0;
      cmp_en_q <= 1'b0;
      cmp_gt_q <= 1'b0;
      irq_en_q <= 1'b0;
      cont_q <= 1'b0;
      chan_q <= adc_ctrl_pkg::CHAN_RST;
      cmp_hi_q <= 2'h0;
      cmp_lo_q <= 8'h00;
      pin_lo_q <= adc_ctrl_pkg::PIN_RST;
      pin_hi_q <= adc_ctrl_pkg::PIN_RST;
    end else if (deep_stop_i) begin // see R2
      cfg_q <= adc_ctrl_pkg::CONFIG_RST;
      hw_trig_q <= 1'b0;
      cmp_en_q <= 1'b0;
      cmp_gt_q <= 1'b0;
      irq_en_q <= 1'b0;
      cont_q <= 1'b0;
      chan_q <= adc_ctrl_pkg::CHAN_RST;
      cmp_hi_q <= 2'h0;
      cmp_lo_q <= 8'h00;
      pin_lo_q <= adc_ctrl_pkg::PIN_RST;
      pin_hi_q <= adc_ctrl_pkg::PIN_RST;
    end else if (wr_en_i) begin
      case (addr_i)
        adc_ctrl_pkg::OFS_CONFIG: cfg_q <= wr_data_i; // see R3 see R4 see R7
        adc_ctrl_pkg::OFS_TRIG_CMP: begin // see R11
          hw_trig_q <= wr_data_i[adc_ctrl_pkg::TC_HW_TRIG];
          cmp_en_q <= wr_data_i[adc_ctrl_pkg::TC_CMP_EN];
          cmp_gt_q <= wr_data_i[adc_ctrl_pkg::TC_CMP_GT];
        end
        adc_ctrl_pkg::OFS_CHAN_CTRL: begin // see R15
          irq_en_q <= wr_data_i[adc_ctrl_pkg::CC_IRQ_EN];
          cont_q <= wr_data_i[adc_ctrl_pkg::CC_CONT];
          chan_q <= wr_data_i[adc_ctrl_pkg::CC_CHAN_MSB:0];
        end
        adc_ctrl_pkg::OFS_CMP_HI: cmp_hi_q <= wr_data_i[1:0];
        adc_ctrl_pkg::OFS_CMP_LO: cmp_lo_q <= wr_data_i;
        adc_ctrl_pkg::OFS_PIN_LO: pin_lo_q <= wr_data_i; // see R18
        adc_ctrl_pkg::OFS_PIN_HI: pin_hi_q <= wr_data_i;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read port and outputs
  // ----------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_en_i) begin
      case (addr_i)
        adc_ctrl_pkg::OFS_CHAN_CTRL: rd_data_o <= {done_q, irq_en_q, cont_q, chan_q};
        adc_ctrl_pkg::OFS_TRIG_CMP:
          rd_data_o <= {state_q != adc_ctrl_pkg::ST_IDLE, hw_trig_q, cmp_en_q, cmp_gt_q,
                        4'h0}; // see R8 see R11
        adc_ctrl_pkg::OFS_RESULT_HI: rd_data_o <= {6'h00, result_q[9:8]};
        adc_ctrl_pkg::OFS_RESULT_LO: rd_data_o <= result_q[7:0];
        adc_ctrl_pkg::OFS_CMP_HI: rd_data_o <= {6'h00, cmp_hi_q};
        adc_ctrl_pkg::OFS_CMP_LO: rd_data_o <= cmp_lo_q;
        adc_ctrl_pkg::OFS_CONFIG: rd_data_o <= cfg_q;
        adc_ctrl_pkg::OFS_PIN_LO: rd_data_o <= pin_lo_q;
        adc_ctrl_pkg::OFS_PIN_HI: rd_data_o <= pin_hi_q;
        default: rd_data_o <= 8'h00;
      endcase
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= done_q && irq_en_q && !deep_stop_i; // see R13
    end
  end

  assign dac_code_o = sar_q;
  assign sample_o = sample_q;
  assign channel_o = chan_q;
  assign low_power_o = cfg_q[adc_ctrl_pkg::CFG_LOW_POWER]; // see R3
  assign pin_disable_o = PIN_COUNT'({pin_hi_q, pin_lo_q}); // see R18

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  stop_clears_a: assert property (deep_stop_i |=> state_q == adc_ctrl_pkg::ST_IDLE // see R1
      && cfg_q == adc_ctrl_pkg::CONFIG_RST && !done_q && !irq_en_q && !cont_q)
    else $error("deep stop did not clear converter");
  stop_result_a: assert property (deep_stop_i |=> result_q == adc_ctrl_pkg::RESULT_RST // see R2
      && !lock_q && pin_lo_q == adc_ctrl_pkg::PIN_RST)
    else $error("deep stop left result or pins set");
  tc_reserved_a: assert property (rd_en_i && addr_i == adc_ctrl_pkg::OFS_TRIG_CMP // see R11
      |=> rd_data_o[3:0] == 4'h0 && rd_data_o[7] == $past(state_q != adc_ctrl_pkg::ST_IDLE))
    else $error("trigger register readback wrong");
  sw_start_a: assert property (wr_chan && !hw_trig_q && !deep_stop_i // see R24
      |=> state_q == adc_ctrl_pkg::ST_SAMPLE && sample_o && cnt_q == 5'h00)
    else $error("software trigger did not restart");
  hw_arm_a: assert property (wr_chan && hw_trig_q && !hw_trig_i && !deep_stop_i // see R9
      |=> state_q == adc_ctrl_pkg::ST_IDLE)
    else $error("hardware trigger mode started on write");
  done_set_a: assert property (accept && !deep_stop_i // see R12
      |=> done_q && result_q == $past(conv_code))
    else $error("completion not recorded");
  irq_path_a: assert property ((done_q && irq_en_q && !deep_stop_i)[*2] |-> irq_o) // see R13
    else $error("interrupt missing");
  lock_hold_a: assert property (finish && lock_q && !deep_stop_i // see R16
      |=> $stable(result_q))
    else $error("locked result overwritten");
  cmp_fail_a: assert property (finish && cmp_en_q && !cmp_hit && !deep_stop_i // see R23
      |=> $stable(result_q) && done_q == $past(done_q && !wr_chan && !rd_lo))
    else $error("failed compare changed result");
  sample_len_a: assert property ($rose(state_q == adc_ctrl_pkg::ST_CONVERT) // see R21
      |-> cnt_q == sample_ticks)
    else $error("sample window length wrong");
  cont_next_a: assert property (finish && cont_q && !wr_chan && !deep_stop_i // see R14
      |=> state_q == adc_ctrl_pkg::ST_SAMPLE)
    else $error("continuous mode did not restart");
  chan_sel_a: assert property (wr_chan && !deep_stop_i // see R15
      |=> channel_o == $past(wr_data_i[adc_ctrl_pkg::CC_CHAN_MSB:0]))
    else $error("channel select not taken");
  pin_ctrl_a: assert property (!deep_stop_i && wr_en_i // see R18
      && addr_i == adc_ctrl_pkg::OFS_PIN_LO |=> pin_disable_o[0] == $past(wr_data_i[0]))
    else $error("pin control not applied");
  low_power_a: assert property (!deep_stop_i && wr_en_i // see R3
      && addr_i == adc_ctrl_pkg::OFS_CONFIG
      |=> low_power_o == $past(wr_data_i[adc_ctrl_pkg::CFG_LOW_POWER]))
    else $error("low power select not applied");
  done_ro_a: assert property (wr_chan && !accept |=> !done_q) // see R12
    else $error("completion flag written by software");

  single_done_c: cover property (finish ##1 done_q);
  compare_miss_c: cover property (finish && cmp_en_q && !cmp_hit);
  locked_drop_c: cover property (finish && lock_q);
  cont_run_c: cover property (finish && cont_q ##[1:200] finish);
  hw_start_c: cover property (hw_trig_q && hw_trig_i && state_q == adc_ctrl_pkg::ST_IDLE);
endmodule : sar_adc_control_regs
`default_nettype wire
